/* File: include/srp_defs.vh */
// Purpose: Constants for the sample record and playback controller.
// Assumes: pclk at 25 MHz; one 8-bit audio word per sample tick.
// Notes: Register offsets are APB byte addresses.
// Contract
// - One sample is held, never longer than 1.55 seconds.
// - Sample is discarded on configuration or program change; volatile storage.
// - Sampling works only while configuration 8 is selected.
// - Audio-trigger recording: record key arms, capture starts when level crosses -18dB.
// - Without audio trigger, the record key starts capture at once.
// - One-shot playback runs start to end then stops.
// - Looping playback repeats; playback key stops it.
// - One-shot: each playback key press restarts from sample start.
// - Audio-trigger mode: level above -18dB starts playback.
// - Playback key still starts playback in audio-trigger mode.
// - Audio-trigger playback never loops.
// - Audio re-trigger only after level has dropped below threshold.
// - Note single pass mode: note-on plays to end regardless of hold.
// - Note held mode: playback stops when the starting note is released.
// - Note triggering off ignores note-on and note-off.
// - Looping with single-pass note trigger plays until a mode changes or config left.
// - Base note plus low and high limits; out-of-range notes do not trigger.
// - Start and length adjust playback without altering recorded data.
// - Start point set in 10 millisecond steps.
// - Pitch tracks over two octaves, folding outside notes by whole octaves.
`ifndef SRP_DEFS_VH
`define SRP_DEFS_VH
`define SRP_CLK_HZ 25000000
`define SRP_SAMPLE_MS 1550
`define SRP_STEP_MS 10
`define SRP_CAP_STEPS 155
`define SRP_CFG_SAMPLING 4'h8
`define SRP_PB_ONESHOT 2'h0
`define SRP_PB_LOOP 2'h1
`define SRP_PB_AUDIO 2'h2
`define SRP_NT_OFF 2'h0
`define SRP_NT_HELD 2'h1
`define SRP_NT_SINGLE 2'h2
`define SRP_REG_CTRL 12'h000
`define SRP_REG_NOTE 12'h004
`define SRP_REG_TRIM 12'h008
`define SRP_REG_STAT 12'h00C
`define SRP_REG_LEN 12'h010
`define SRP_CTRL_RST 32'h00000000
`define SRP_NOTE_RST 32'h007F3C00
`define SRP_TRIM_RST 32'h009B0000
`endif

/* File: hdl/srp_sync.v */
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Destination clock is pclk.
// Notes: Width is a parameter.
`timescale 1ns/1ps
`default_nettype none
module srp_sync #(
  parameter W = 1
) (
  input wire pclk, // Clock.
  input wire presetn, // Async reset, active low.
  input wire [W-1:0] d, // Asynchronous input.
  output reg [W-1:0] q // Synchronised output.
);
  reg [W-1:0] meta_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // srp_sync
`default_nettype wire

/* File: hdl/srp_pitch.v */
// Purpose: Fold a note into the two octaves above the base and give a rate step.
// Assumes: Step is in 1/16 of the original rate.
// Notes: Semitone table is coarse; rate is approximate by design.
`timescale 1ns/1ps
`default_nettype none
module srp_pitch (
  input wire [6:0] note, // Played note.
  input wire [6:0] base, // Base note, original pitch.
  output reg [6:0] step // Address step in sixteenths.
);
  reg signed [8:0] diff;
  reg [4:0] semi;
  always @* begin
    diff = $signed({2'b00, note}) - $signed({2'b00, base});
    while_fold: begin
      // Bring the interval into 0..23 semitones by whole octaves.
      if (diff < 0) diff = diff + 9'sd12 * ((9'sd11 - diff) / 9'sd12);
      diff = diff % 9'sd24;
    end
    semi = diff[4:0];
    if (semi >= 5'd12)
      step = 7'd32 + {2'b00, semi - 5'd12} * 7'd3;
    else
      step = 7'd16 + {2'b00, semi} + {3'b000, semi[4:1]};
  end
endmodule // srp_pitch
`default_nettype wire

/* File: hdl/srp_core.v */
// Purpose: Single-sample recorder and player with key, audio and note triggers.
// Assumes: APB slave; pin inputs are asynchronous and synchronised here.
// Notes: Storage is a flip-flop array addressed by index; depth is a parameter.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "srp_defs.vh"
module srp_core #(
  parameter DEPTH = 256, // Storage words for the full sample time.
  parameter AW = 8, // Address width.
  parameter DW = 8 // Audio word width.
) (
  input wire pclk, // Clock, 25 MHz.
  input wire presetn, // Async reset, active low.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB direction.
  input wire [11:0] paddr, // APB byte address.
  input wire [31:0] pwdata, // APB write data.
  output reg [31:0] prdata, // APB read data.
  output reg pready, // APB ready.
  output reg pslverr, // APB error on unmapped address.
  input wire sample_tick, // Audio sample rate enable, same clock.
  input wire [DW-1:0] audio_in, // Audio input word, same clock.
  input wire level_above, // Input above -18dB, asynchronous pin.
  input wire record_key, // Record key, asynchronous pin.
  input wire playback_key, // Playback key, asynchronous pin.
  input wire [3:0] cfg_sel, // Active configuration, same clock.
  input wire program_chg, // Program change pulse, same clock.
  input wire note_on, // Note-on pulse, same clock.
  input wire note_off, // Note-off pulse, same clock.
  input wire [6:0] note_num, // Note number with the pulse.
  output reg [DW-1:0] audio_out, // Played sample word.
  output reg playing, // Playback active.
  output reg recording // Capture active.
);
  // ==========================================================
  // Input synchronisers
  wire [2:0] pins_s;
  srp_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({level_above, record_key, playback_key}),
    .q(pins_s)
  );
  wire lvl = pins_s[2];
  reg rec_k_ff;
  reg pb_k_ff;
  reg lvl_d_ff;
  wire rec_press = pins_s[1] & ~rec_k_ff;
  wire pb_press = pins_s[0] & ~pb_k_ff;
  wire lvl_rise = lvl & ~lvl_d_ff;

  // ==========================================================
  // Registers
  reg [31:0] ctrl_ff;
  reg [31:0] note_ff;
  reg [31:0] trim_ff;
  wire [1:0] pb_mode = ctrl_ff[1:0];
  wire [1:0] nt_mode = ctrl_ff[3:2];
  wire audio_rec = ctrl_ff[4];
  wire [6:0] low_lim = note_ff[6:0];
  wire [6:0] base_note = note_ff[14:8];
  wire [6:0] high_lim = note_ff[22:16];
  wire [7:0] start_step = trim_ff[7:0];
  wire [7:0] len_step = trim_ff[23:16];
  wire wr = psel & penable & pwrite;
  wire in_cfg = (cfg_sel == `SRP_CFG_SAMPLING);
  reg [3:0] cfg_d_ff;
  wire discard = (cfg_sel != cfg_d_ff) | program_chg;
  wire mode_wr = wr & (paddr == `SRP_REG_CTRL) & (pwdata[3:0] != ctrl_ff[3:0]);

  // ==========================================================
  // State machine
  localparam ST_IDLE = 3'd0;
  localparam ST_ARM = 3'd1;
  localparam ST_REC = 3'd2;
  localparam ST_PLAY = 3'd3;
  reg [2:0] st_ff;
  reg [2:0] nxt_st;
  reg [DW-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wptr_ff;
  reg [AW-1:0] rec_len_ff;
  reg [AW+3:0] rptr_ff;
  reg [AW+3:0] nxt_rptr;
  reg [AW-1:0] end_ff;
  reg [6:0] step_ff;
  reg [6:0] held_note_ff;
  reg gated_ff;
  reg loop_ff;
  reg retrig_ok_ff;
  reg has_sample_ff;
  wire [6:0] pstep;
  srp_pitch u_pitch (
    .note(note_num),
    .base(base_note),
    .step(pstep)
  );

  // Start and end in storage words; one step is 10 ms of the full 1.55 s.
  wire [31:0] start_x = ({24'h000000, start_step} * DEPTH) / `SRP_CAP_STEPS;
  wire [31:0] len_x = ({24'h000000, len_step} * DEPTH) / `SRP_CAP_STEPS;
  wire [15:0] start_w = start_x[15:0];
  wire [15:0] len_w = len_x[15:0];
  // Step widened without a zero-width replication, which a small AW would need.
  wire [AW+10:0] step_x = {{(AW+4){1'b0}}, step_ff};
  wire [15:0] end_raw = start_w + len_w;
  // End clips at the recorded end but the length setting is kept.
  wire [AW-1:0] end_w = (end_raw >= {8'h00, rec_len_ff}) ? rec_len_ff : end_raw[AW-1:0];
  wire note_ok = note_on & in_cfg & (nt_mode != `SRP_NT_OFF)
    & (note_num >= low_lim) & (note_num <= high_lim);
  wire audio_trig = (pb_mode == `SRP_PB_AUDIO) & lvl_rise & retrig_ok_ff;
  wire key_start = pb_press & ~(st_ff == ST_PLAY & loop_ff);
  wire trig = has_sample_ff & in_cfg & (key_start | audio_trig | note_ok);
  wire at_end = (rptr_ff[AW+3:4] >= end_ff);

  always @* begin
    nxt_st = st_ff;
    nxt_rptr = rptr_ff;
    case (st_ff)
      ST_IDLE: begin
        if (rec_press & in_cfg)
          nxt_st = audio_rec ? ST_ARM : ST_REC;
      end
      ST_ARM: begin
        if (lvl)
          nxt_st = ST_REC;
      end
      ST_REC: begin
        if (sample_tick & (wptr_ff == DEPTH - 1))
          nxt_st = ST_IDLE;
      end
      ST_PLAY: begin
        if (pb_press & loop_ff)
          nxt_st = ST_IDLE;
        else if (gated_ff & note_off & (note_num == held_note_ff))
          nxt_st = ST_IDLE;
        else if (mode_wr & loop_ff)
          nxt_st = ST_IDLE;
        else if (sample_tick & at_end) begin
          if (loop_ff)
            nxt_rptr = {start_w[AW-1:0], 4'h0};
          else
            nxt_st = ST_IDLE;
        end else if (sample_tick)
          nxt_rptr = rptr_ff + step_x[AW+3:0];
      end
      default: nxt_st = ST_IDLE;
    endcase
    if (trig & (st_ff == ST_IDLE | st_ff == ST_PLAY)) begin
      nxt_st = ST_PLAY;
      nxt_rptr = {start_w[AW-1:0], 4'h0};
    end
    if (discard | ~in_cfg)
      nxt_st = ST_IDLE;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
      rptr_ff <= {(AW+4){1'b0}};
      wptr_ff <= {AW{1'b0}};
      rec_len_ff <= {AW{1'b0}};
      end_ff <= {AW{1'b0}};
      step_ff <= 7'd16;
      held_note_ff <= 7'd0;
      gated_ff <= 1'b0;
      loop_ff <= 1'b0;
      retrig_ok_ff <= 1'b1;
      has_sample_ff <= 1'b0;
      rec_k_ff <= 1'b0;
      pb_k_ff <= 1'b0;
      lvl_d_ff <= 1'b0;
      cfg_d_ff <= 4'h0;
      audio_out <= {DW{1'b0}};
      playing <= 1'b0;
      recording <= 1'b0;
    end else begin
      rec_k_ff <= pins_s[1];
      pb_k_ff <= pins_s[0];
      lvl_d_ff <= lvl;
      cfg_d_ff <= cfg_sel;
      st_ff <= nxt_st;
      rptr_ff <= nxt_rptr;
      end_ff <= end_w;
      if (audio_trig)
        retrig_ok_ff <= 1'b0;
      else if (~lvl)
        retrig_ok_ff <= 1'b1;
      if (discard)
        has_sample_ff <= 1'b0;
      if (st_ff != ST_REC & nxt_st == ST_REC)
        wptr_ff <= {AW{1'b0}};
      else if (st_ff == ST_REC & sample_tick) begin
        mem_ff[wptr_ff] <= audio_in;
        wptr_ff <= wptr_ff + 1'b1;
        if (wptr_ff == DEPTH - 1) begin
          rec_len_ff <= wptr_ff;
          has_sample_ff <= ~discard;
        end
      end
      if (trig & nxt_st == ST_PLAY) begin
        loop_ff <= (pb_mode == `SRP_PB_LOOP) & ~audio_trig;
        gated_ff <= note_ok & (nt_mode == `SRP_NT_HELD);
        held_note_ff <= note_num;
        step_ff <= note_ok ? pstep : 7'd16;
      end
      if (st_ff == ST_PLAY)
        audio_out <= mem_ff[rptr_ff[AW+3:4]];
      else
        audio_out <= {DW{1'b0}};
      playing <= (nxt_st == ST_PLAY);
      recording <= (nxt_st == ST_REC);
    end
  end

  // ==========================================================
  // APB slave: zero wait states, error on unmapped address.
  wire mapped = (paddr == `SRP_REG_CTRL) | (paddr == `SRP_REG_NOTE) | (paddr == `SRP_REG_TRIM)
    | (paddr == `SRP_REG_STAT) | (paddr == `SRP_REG_LEN);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `SRP_CTRL_RST;
      note_ff <= `SRP_NOTE_RST;
      trim_ff <= `SRP_TRIM_RST;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (wr & pready) begin
        case (paddr)
          `SRP_REG_CTRL: ctrl_ff <= {27'h0000000, pwdata[4:0]};
          `SRP_REG_NOTE: note_ff <= {9'h000, pwdata[22:16], 1'b0, pwdata[14:8], 1'b0, pwdata[6:0]};
          `SRP_REG_TRIM: trim_ff <= {8'h00, pwdata[23:16], 8'h00, pwdata[7:0]};
          default: ;
        endcase
      end
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `SRP_REG_CTRL: prdata <= ctrl_ff;
          `SRP_REG_NOTE: prdata <= note_ff;
          `SRP_REG_TRIM: prdata <= trim_ff;
          `SRP_REG_STAT: prdata <= {27'h0000000, has_sample_ff, in_cfg, playing, recording, st_ff == ST_ARM};
          `SRP_REG_LEN: prdata <= {{(32-AW){1'b0}}, rec_len_ff};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // srp_core
`default_nettype wire

/* File: dv/srp_checker.sv */
// Purpose: Port assertions for srp_core.
// Assumes: Registered outputs and one-cycle APB access.
// Notes: CTRL is shadowed from completed APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "srp_defs.vh"
module srp_checker #(
  parameter DEPTH = 256, // Storage words.
  parameter AW = 8 // Address width.
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // APB.
  input wire logic penable, // APB.
  input wire logic pwrite, // APB.
  input wire logic [11:0] paddr, // APB.
  input wire logic [31:0] pwdata, // APB.
  input wire logic pready, // APB.
  input wire logic pslverr, // APB.
  input wire logic sample_tick, // Audio rate.
  input wire logic level_above, // Threshold pin.
  input wire logic record_key, // Record key.
  input wire logic [3:0] cfg_sel, // Configuration.
  input wire logic note_off, // Note release.
  input wire logic note_on, // Note press.
  input wire logic [6:0] note_num, // Note number.
  input wire logic playing, // Playback.
  input wire logic recording // Capture.
);
  // ======
  // Helper state.
  logic [4:0] ctl_ff;
  logic [6:0] note_ff;
  logic [AW+1:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= 5'h00;
      note_ff <= 7'h00;
      cnt_ff <= '0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == `SRP_REG_CTRL) begin
        ctl_ff <= pwdata[4:0];
      end
      if (note_on) begin
        note_ff <= note_num;
      end
      cnt_ff <= recording ? cnt_ff + {{(AW+1){1'b0}}, sample_tick} : '0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_cfg_gate: assert property ((cfg_sel != `SRP_CFG_SAMPLING)[*3] |-> !playing && !recording)
    else $error("activity outside sampling config");
  chk_cap_limit: assert property (cnt_ff <= DEPTH)
    else $error("capture longer than capacity");
  chk_rec_now: assert property ($rose(record_key) && !ctl_ff[4] && !recording && !playing
    && cfg_sel == `SRP_CFG_SAMPLING |-> ##[2:6] recording)
    else $error("record key did not start capture");
  chk_rec_armed: assert property ((!level_above)[*6] ##0 ($rose(record_key) && ctl_ff[4])
    |=> (!recording)[*3])
    else $error("capture began without level");
  chk_audio_play: assert property ($rose(level_above) && ctl_ff[1:0] == 2'h2 && !ctl_ff[4]
    && !playing && !recording && cfg_sel == `SRP_CFG_SAMPLING |-> ##[2:6] playing)
    else $error("level did not start playback");
  chk_note_gate: assert property (ctl_ff[3:2] == 2'h1 && note_off && note_num == note_ff
    && playing |-> ##[1:4] !playing)
    else $error("release did not stop playback");
endmodule // srp_checker
bind srp_core srp_checker #(.DEPTH(DEPTH), .AW(AW)) u_srp_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .sample_tick(sample_tick), .level_above(level_above), .record_key(record_key),
  .cfg_sel(cfg_sel), .note_off(note_off), .note_on(note_on), .note_num(note_num), .playing(playing),
  .recording(recording));
`default_nettype wire

/* File: dv/srp_src.sv */
// Purpose: Audio source and note keyboard model.
// Assumes: Ticks every DIV cycles; notes are one-cycle pulses.
// Notes: Note number shows the inverse after each note-on or note-off pulse.
`timescale 1ns/1ps
`default_nettype none
module srp_src #(
  parameter DIV = 8 // Cycles per sample tick.
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  output logic sample_tick, // Audio rate.
  output logic [7:0] audio_in, // Audio word.
  output logic level_above, // Threshold pin.
  output logic note_on, // Note press.
  output logic note_off, // Note release.
  output logic [6:0] note_num // Note number.
);
  // ======
  // Source.
  int div_ff;
  initial begin
    level_above = 1'b0;
    note_on = 1'b0;
    note_off = 1'b0;
    note_num = 7'h00;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 0;
      sample_tick <= 1'b0;
      audio_in <= 8'h00;
    end else begin
      div_ff <= (div_ff == DIV - 1) ? 0 : div_ff + 1;
      sample_tick <= (div_ff == DIV - 1);
      audio_in <= sample_tick ? audio_in + 8'h01 : audio_in;
    end
  end
  task automatic level(input logic v);
    @(posedge pclk);
    level_above <= v;
  endtask
  task automatic note(input logic on, input logic [6:0] n);
    @(posedge pclk);
    note_on <= on;
    note_off <= !on;
    note_num <= n;
    @(posedge pclk);
    note_on <= 1'b0;
    note_off <= 1'b0;
    note_num <= ~n;
  endtask
endmodule // srp_src
`default_nettype wire

/* File: dv/tb_srp_core.sv */
// Purpose: Directed bench for srp_core.
// Assumes: DEPTH of 8 words keeps each pass short.
// Notes: Waits are bounded and end the run when exhausted.
`timescale 1ns/1ps
`default_nettype none
`include "srp_defs.vh"
module tb_srp_core;
  logic pclk = 0;
  logic presetn = 0;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [7:0] audio_o;
  logic [31:0] prdata, rd_v;
  logic pready, pslverr, err_v, playing, recording, sample_tick, level_above, note_on, note_off;
  logic [7:0] audio_in;
  logic [6:0] note_num;
  logic rec_k = 0;
  logic pb_k = 0;
  logic [3:0] cfg_sel = 4'h0;
  logic program_chg;
  int err_count = 0;
  int n_checks = 0;
  srp_core #(.DEPTH(8), .AW(3)) u_srp_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick), .audio_in(audio_in),
    .level_above(level_above), .record_key(rec_k), .playback_key(pb_k), .cfg_sel(cfg_sel),
    .program_chg(program_chg), .note_on(note_on), .note_off(note_off), .note_num(note_num),
    .audio_out(audio_o), .playing(playing), .recording(recording));
  srp_src u_srp_src (.pclk(pclk), .presetn(presetn), .sample_tick(sample_tick), .audio_in(audio_in),
    .level_above(level_above), .note_on(note_on), .note_off(note_off), .note_num(note_num));
  initial begin
    forever #20 pclk = ~pclk;
  end
  // ======
  // Tasks.
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 0;
    penable <= 0;
    if (i >= 50) begin
      chk("pready", 0, 1);
      tally_and_finish();
    end
  endtask
  // Waits for playing (r=0) or recording (r=1) to reach v.
  task automatic wt(input logic r, input logic v);
    int i;
    for (i = 0; i < 4000 && (r ? recording : playing) !== v; i++) begin
      @(posedge pclk);
    end
    chk(r ? "recording" : "playing", r ? recording : playing, v);
    if (i >= 4000) begin
      tally_and_finish();
    end
  endtask
  task automatic press(input logic r);
    @(posedge pclk);
    rec_k <= r;
    pb_k <= !r;
    idle(6);
    rec_k <= 0;
    pb_k <= 0;
  endtask
  // ======
  // Sequence.
  initial begin
    psel <= 0;
    penable <= 0;
    pwrite <= 0;
    paddr <= 12'h000;
    pwdata <= 32'h00000000;
    program_chg <= 0;
    idle(2);
    presetn <= 1;
    apb(0, `SRP_REG_CTRL, 0);
    chk("ctrl", rd_v, `SRP_CTRL_RST);
    apb(0, `SRP_REG_NOTE, 0);
    chk("note", rd_v, `SRP_NOTE_RST);
    apb(0, `SRP_REG_TRIM, 0);
    chk("trim", rd_v, `SRP_TRIM_RST);
    apb(1, 12'h020, 32'hFFFFFFFF);
    chk("slverr", err_v, 1);
    press(0);
    idle(10);
    chk("playing", playing, 0);
    cfg_sel <= 4'h8;
    apb(1, `SRP_REG_CTRL, 0);
    press(1);
    wt(1, 1);
    wt(1, 0);
    apb(0, `SRP_REG_LEN, 0);
    chk("len", rd_v, 7);
    press(0);
    wt(0, 1);
    wt(0, 0);
    idle(2);
    chk("audio_out", audio_o, 0);
    press(0);
    wt(0, 1);
    idle(30);
    press(0);
    idle(35);
    chk("playing", playing, 1);
    wt(0, 0);
    apb(1, `SRP_REG_CTRL, 1);
    press(0);
    idle(150);
    chk("playing", playing, 1);
    press(0);
    wt(0, 0);
    apb(1, `SRP_REG_CTRL, 2);
    u_srp_src.level(1);
    wt(0, 1);
    wt(0, 0);
    idle(100);
    chk("playing", playing, 0);
    u_srp_src.level(0);
    idle(6);
    u_srp_src.level(1);
    wt(0, 1);
    wt(0, 0);
    u_srp_src.level(0);
    press(0);
    wt(0, 1);
    wt(0, 0);
    apb(1, `SRP_REG_CTRL, 0);
    u_srp_src.note(1, 7'd60);
    idle(20);
    chk("playing", playing, 0);
    apb(1, `SRP_REG_CTRL, 4);
    u_srp_src.note(1, 7'd60);
    wt(0, 1);
    u_srp_src.note(0, 7'd60);
    idle(4);
    chk("playing", playing, 0);
    apb(1, `SRP_REG_CTRL, 8);
    u_srp_src.note(1, 7'd60);
    u_srp_src.note(0, 7'd60);
    idle(10);
    chk("playing", playing, 1);
    wt(0, 0);
    apb(1, `SRP_REG_NOTE, 32'h00463C32);
    u_srp_src.note(1, 7'd80);
    idle(20);
    chk("playing", playing, 0);
    u_srp_src.note(1, 7'd70);
    wt(0, 1);
    wt(0, 0);
    apb(1, `SRP_REG_CTRL, 9);
    u_srp_src.note(1, 7'd60);
    idle(200);
    chk("playing", playing, 1);
    apb(1, `SRP_REG_CTRL, 8);
    wt(0, 0);
    apb(1, `SRP_REG_CTRL, 32'h10);
    press(1);
    idle(20);
    chk("recording", recording, 0);
    u_srp_src.level(1);
    wt(1, 1);
    wt(1, 0);
    u_srp_src.level(0);
    program_chg <= 1;
    idle(1);
    program_chg <= 0;
    apb(0, `SRP_REG_STAT, 0);
    chk("held", rd_v[4], 0);
    tally_and_finish();
  end
endmodule // tb_srp_core
`default_nettype wire
